/* common/scas_pkg.sv */
// package: socket close / address resolution state codes, types and constants
package scas_pkg;

  localparam logic [7:0] SCAS_CODE_CLOSED = 8'h00;
  localparam logic [7:0] SCAS_CODE_TCP_INITIAL = 8'h13;
  localparam logic [7:0] SCAS_CODE_CONNECT_SENT = 8'h15;
  localparam logic [7:0] SCAS_CODE_FINAL_ACK_WAIT = 8'h1d;
  localparam logic [7:0] SCAS_CODE_DATAGRAM_OPEN = 8'h22;
  localparam logic [7:0] SCAS_CODE_RAW_IP_OPEN = 8'h32;
  localparam logic [7:0] SCAS_CODE_ADDR_RESOLVE = 8'h01;

  localparam logic [31:0] SCAS_DEST_IP_RESET = 32'h0000_0000;
  localparam logic [47:0] SCAS_HW_ADDR_RESET = 48'h0000_0000_0000;

  // socket mode selected when the socket was opened
  typedef enum logic [1:0] {
    SCAS_MODE_TCP = 2'h0,
    SCAS_MODE_UDP = 2'h1,
    SCAS_MODE_RAW = 2'h2
  } scas_mode_t;

  typedef enum logic [6:0] {
    STATE_CLOSED = 7'h01,
    STATE_TCP_INITIAL = 7'h02,
    STATE_CONNECT_SENT = 7'h04,
    STATE_FINAL_ACK_WAIT = 7'h08,
    STATE_DATAGRAM_OPEN = 7'h10,
    STATE_RAW_IP_OPEN = 7'h20,
    STATE_ADDR_RESOLVE = 7'h40
  } scas_state_t;

  // one-cycle host command strobes
  typedef struct packed {
    logic open;
    logic connect;
    logic send;
    logic close;
  } scas_cmd_t;

  // one-cycle link-side event strobes
  typedef struct packed {
    logic peer_fin;
    logic final_ack;
    logic ack_timeout;
    logic resolve_reply;
    logic resolve_timeout;
  } scas_evt_t;

endpackage : scas_pkg

/* hdl/scas_code_map.sv */
// state to status-code mapping
`timescale 1ns/1ps
module scas_code_map (
  input wire scas_pkg::scas_state_t state_in,
  output logic [7:0] code_out
);
  always_comb begin
    case (state_in)
      scas_pkg::STATE_CLOSED: code_out = scas_pkg::SCAS_CODE_CLOSED;
      scas_pkg::STATE_TCP_INITIAL: code_out = scas_pkg::SCAS_CODE_TCP_INITIAL;
      scas_pkg::STATE_CONNECT_SENT: code_out = scas_pkg::SCAS_CODE_CONNECT_SENT;
      scas_pkg::STATE_FINAL_ACK_WAIT: code_out = scas_pkg::SCAS_CODE_FINAL_ACK_WAIT;
      scas_pkg::STATE_DATAGRAM_OPEN: code_out = scas_pkg::SCAS_CODE_DATAGRAM_OPEN;
      scas_pkg::STATE_RAW_IP_OPEN: code_out = scas_pkg::SCAS_CODE_RAW_IP_OPEN;
      scas_pkg::STATE_ADDR_RESOLVE: code_out = scas_pkg::SCAS_CODE_ADDR_RESOLVE;
      default: code_out = scas_pkg::SCAS_CODE_CLOSED;
    endcase
  end
endmodule : scas_code_map

/* hdl/scas_socket_fsm.sv */
// socket status state machine: final-ack wait and address resolution
`timescale 1ns/1ps
// Notes on behaviour
// [R1] passive close waiting for ack of our fin reports code 0x1d
// [R2] ack timeout in final-ack wait sets timeout flag and closes socket
// [R3] resolution reports 0x01; entered on send in udp/raw or connect from tcp initial
// [R4] resolution reply stores hardware address, enters datagram, raw or connect-sent
// [R5] resolution timeout sets flag; udp/raw return to open state, tcp closes
// [R6] udp/raw resolve only when destination ip changed, else reuse stored address
// [R7] closed state reports code 0x00
// [R8] udp open state reports code 0x22
// [R9] raw-ip open state reports code 0x32
// [R10] connect-sent state reports code 0x15
// [R11] status code follows every state transition
module scas_socket_fsm #(
  parameter int IP_W = 32,
  parameter int HW_W = 48
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire scas_pkg::scas_mode_t mode_in,
  input wire scas_pkg::scas_cmd_t cmd_in,
  input wire scas_pkg::scas_evt_t evt_in,
  input wire logic [IP_W-1:0] dest_ip_in,
  input wire logic [HW_W-1:0] reply_hw_addr_in,
  input wire logic timeout_clear_in,
  output logic [7:0] status_code_out,
  output logic timeout_flag_out,
  output logic resolve_req_out,
  output logic [HW_W-1:0] dest_hw_addr_out
);

  initial begin
    if (IP_W != 32 || HW_W != 48) begin
      $error("scas_socket_fsm: address widths must be 32 and 48");
    end
  end

  scas_pkg::scas_state_t state_q, state_d;
  scas_pkg::scas_mode_t mode_q;
  logic [IP_W-1:0] last_ip_q;
  logic ip_valid_q;
  logic [HW_W-1:0] hw_q;
  logic timeout_q;
  logic ip_changed;
  logic set_timeout;

  // an unseen address counts as changed so the first send always resolves
  assign ip_changed = !ip_valid_q || (dest_ip_in != last_ip_q); // R6

  always_comb begin
    state_d = state_q;
    case (state_q)
      scas_pkg::STATE_CLOSED: begin
        if (cmd_in.open) begin
          case (mode_in)
            scas_pkg::SCAS_MODE_UDP: state_d = scas_pkg::STATE_DATAGRAM_OPEN;
            scas_pkg::SCAS_MODE_RAW: state_d = scas_pkg::STATE_RAW_IP_OPEN;
            default: state_d = scas_pkg::STATE_TCP_INITIAL;
          endcase
        end
      end
      scas_pkg::STATE_TCP_INITIAL: begin
        if (cmd_in.close) begin
          state_d = scas_pkg::STATE_CLOSED;
        end else if (cmd_in.connect) begin
          state_d = scas_pkg::STATE_ADDR_RESOLVE; // R3
        end
      end
      scas_pkg::STATE_DATAGRAM_OPEN,
      scas_pkg::STATE_RAW_IP_OPEN: begin
        if (cmd_in.close) begin
          state_d = scas_pkg::STATE_CLOSED;
        end else if (cmd_in.send && ip_changed) begin
          state_d = scas_pkg::STATE_ADDR_RESOLVE; // R3 R6
        end
      end
      scas_pkg::STATE_CONNECT_SENT: begin
        // the synack path is outside this block; close and fin drive it here
        if (cmd_in.close) begin
          state_d = scas_pkg::STATE_CLOSED;
        end else if (evt_in.peer_fin) begin
          state_d = scas_pkg::STATE_FINAL_ACK_WAIT;
        end
      end
      scas_pkg::STATE_FINAL_ACK_WAIT: begin
        if (cmd_in.close || evt_in.final_ack || evt_in.ack_timeout) begin
          state_d = scas_pkg::STATE_CLOSED; // R2
        end
      end
      scas_pkg::STATE_ADDR_RESOLVE: begin
        if (cmd_in.close) begin
          state_d = scas_pkg::STATE_CLOSED;
        end else if (evt_in.resolve_reply) begin
          case (mode_q) // R4
            scas_pkg::SCAS_MODE_UDP: state_d = scas_pkg::STATE_DATAGRAM_OPEN;
            scas_pkg::SCAS_MODE_RAW: state_d = scas_pkg::STATE_RAW_IP_OPEN;
            default: state_d = scas_pkg::STATE_CONNECT_SENT;
          endcase
        end else if (evt_in.resolve_timeout) begin
          case (mode_q) // R5
            scas_pkg::SCAS_MODE_UDP: state_d = scas_pkg::STATE_DATAGRAM_OPEN;
            scas_pkg::SCAS_MODE_RAW: state_d = scas_pkg::STATE_RAW_IP_OPEN;
            default: state_d = scas_pkg::STATE_CLOSED;
          endcase
        end
      end
      default: state_d = scas_pkg::STATE_CLOSED;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= scas_pkg::STATE_CLOSED;
    end else begin
      state_q <= state_d; // R11
    end
  end

  // mode is latched on open so a later change of mode_in cannot misroute resolution
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_q <= scas_pkg::SCAS_MODE_TCP;
    end else if (state_q == scas_pkg::STATE_CLOSED && cmd_in.open) begin
      mode_q <= mode_in;
    end
  end

  // destination ip seen at the last resolution start
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_ip_q <= scas_pkg::SCAS_DEST_IP_RESET;
      ip_valid_q <= 1'b0;
    end else if (state_d == scas_pkg::STATE_ADDR_RESOLVE &&
                 state_q != scas_pkg::STATE_ADDR_RESOLVE) begin
      last_ip_q <= dest_ip_in; // R6
      ip_valid_q <= 1'b1;
    end else if (state_q == scas_pkg::STATE_ADDR_RESOLVE && evt_in.resolve_timeout) begin
      ip_valid_q <= 1'b0; // failed lookup must retry next send
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hw_q <= scas_pkg::SCAS_HW_ADDR_RESET;
    end else if (state_q == scas_pkg::STATE_ADDR_RESOLVE && !cmd_in.close &&
                 evt_in.resolve_reply) begin
      hw_q <= reply_hw_addr_in; // R4
    end
  end

  assign set_timeout = (state_q == scas_pkg::STATE_FINAL_ACK_WAIT && !cmd_in.close &&
                        !evt_in.final_ack && evt_in.ack_timeout) || // R2
                       (state_q == scas_pkg::STATE_ADDR_RESOLVE && !cmd_in.close &&
                        !evt_in.resolve_reply && evt_in.resolve_timeout); // R5

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timeout_q <= 1'b0;
    end else if (set_timeout) begin
      timeout_q <= 1'b1; // R2 R5
    end else if (timeout_clear_in) begin
      timeout_q <= 1'b0;
    end
  end

  scas_code_map u_code_map (
    .state_in(state_q),
    .code_out(status_code_out) // R1 R3 R7 R8 R9 R10 R11
  );

  assign timeout_flag_out = timeout_q;
  assign resolve_req_out = (state_q == scas_pkg::STATE_ADDR_RESOLVE);
  assign dest_hw_addr_out = hw_q;

  final_ack_code_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_FINAL_ACK_WAIT |-> status_code_out == 8'h1d) // R1
    else $error("final-ack wait code wrong");

  ack_timeout_close_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_FINAL_ACK_WAIT && evt_in.ack_timeout && !cmd_in.close
    |=> state_q == scas_pkg::STATE_CLOSED && timeout_flag_out) // R2
    else $error("ack timeout did not close with flag");

  resolve_entry_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_TCP_INITIAL && cmd_in.connect && !cmd_in.close
    |=> status_code_out == 8'h01 && resolve_req_out) // R3
    else $error("connect did not start resolution");

  resolve_reply_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_ADDR_RESOLVE && evt_in.resolve_reply && !cmd_in.close
    |=> dest_hw_addr_out == $past(reply_hw_addr_in) &&
        state_q != scas_pkg::STATE_ADDR_RESOLVE && state_q != scas_pkg::STATE_CLOSED) // R4
    else $error("resolution reply not taken");

  tcp_resolve_fail_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_ADDR_RESOLVE && mode_q == scas_pkg::SCAS_MODE_TCP &&
    evt_in.resolve_timeout && !evt_in.resolve_reply && !cmd_in.close
    |=> status_code_out == 8'h00 && timeout_flag_out) // R5
    else $error("tcp resolution timeout not closed");

  same_ip_skip_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_DATAGRAM_OPEN && cmd_in.send && !cmd_in.close &&
    ip_valid_q && dest_ip_in == last_ip_q |=> status_code_out == 8'h22) // R6
    else $error("resolution ran for unchanged ip");

  raw_open_code_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_CLOSED && cmd_in.open && mode_in == scas_pkg::SCAS_MODE_RAW
    |=> status_code_out == 8'h32 ##0 $past(status_code_out) == 8'h00) // R7 R9
    else $error("raw open code wrong");

  connect_sent_code_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_CONNECT_SENT |-> status_code_out == 8'h15) // R10
    else $error("connect-sent code wrong");

  udp_open_code_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_DATAGRAM_OPEN |-> status_code_out == 8'h22) // R8
    else $error("datagram open code wrong");

  dgram_resolve_fail_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state_q == scas_pkg::STATE_ADDR_RESOLVE && mode_q == scas_pkg::SCAS_MODE_UDP &&
    evt_in.resolve_timeout && !evt_in.resolve_reply && !cmd_in.close
    |=> status_code_out == 8'h22 && timeout_flag_out) // R5
    else $error("udp resolution timeout did not return to open");

  code_tracks_state_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    $changed(state_q) |-> $changed(status_code_out)) // R11
    else $error("status code did not follow state");

endmodule : scas_socket_fsm

/* verification/scas_peer_model.sv */
// far-side peer: answers address resolution requests after a delay
`timescale 1ns/1ps
module scas_peer_model (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic resolve_req_in,
  input wire logic answer_in,
  input wire logic [3:0] delay_in,
  input wire logic [47:0] hw_addr_in,
  output logic reply_out,
  output logic timeout_out,
  output logic [47:0] hw_addr_out
);
  logic [3:0] wait_q;
  logic done_q;
  // address is valid only with the reply pulse, inverse otherwise
  assign hw_addr_out = reply_out ? hw_addr_in : ~hw_addr_in;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
      reply_out <= 1'b0;
      timeout_out <= 1'b0;
    end else begin
      reply_out <= 1'b0;
      timeout_out <= 1'b0;
      if (!resolve_req_in) begin
        wait_q <= 4'h0;
        done_q <= 1'b0;
      end else if (!done_q && wait_q == delay_in) begin
        reply_out <= answer_in;
        timeout_out <= !answer_in;
        done_q <= 1'b1;
      end else if (!done_q) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : scas_peer_model

/* verification/scas_socket_fsm_test.sv */
// self-checking testbench for the socket status state machine
`timescale 1ns/1ps
module scas_socket_fsm_test;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  scas_pkg::scas_mode_t mode = scas_pkg::SCAS_MODE_TCP;
  scas_pkg::scas_cmd_t cmd = '0;
  scas_pkg::scas_evt_t tb_evt = '0;
  scas_pkg::scas_evt_t evt;
  logic [31:0] dest_ip = 32'h0;
  logic clr = 1'b0;
  logic answer = 1'b1;
  logic [3:0] delay = 4'h0;
  logic [47:0] peer_addr = 48'h0;
  logic [7:0] code;
  logic flag, req, p_reply, p_tmo;
  logic [47:0] hw_addr, p_addr;
  logic [8:0] prev = 9'h000;
  logic [15:0] rnd = 16'h5856;
  logic [7:0] exp_code = 8'h00;
  logic exp_flag = 1'b0;
  logic [8:0] exp_q[$];
  int err_total = 0;
  int checked = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  assign evt = tb_evt | {3'h0, p_reply, p_tmo};
  scas_socket_fsm i_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .mode_in(mode),
    .cmd_in(cmd), .evt_in(evt), .dest_ip_in(dest_ip), .reply_hw_addr_in(p_addr),
    .timeout_clear_in(clr), .status_code_out(code), .timeout_flag_out(flag),
    .resolve_req_out(req), .dest_hw_addr_out(hw_addr));
  scas_peer_model i_peer (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .resolve_req_in(req), .answer_in(answer), .delay_in(delay), .hw_addr_in(peer_addr),
    .reply_out(p_reply), .timeout_out(p_tmo), .hw_addr_out(p_addr));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic note(input logic [7:0] c);
    exp_code = c;
    exp_q.push_back({exp_flag, c});
  endtask : note
  task automatic drive(input logic [3:0] c, input logic [4:0] e, input logic k);
    @(posedge sys_clk_in);
    cmd <= c;
    tb_evt <= e;
    clr <= k;
    @(posedge sys_clk_in);
    cmd <= '0;
    tb_evt <= '0;
    clr <= 1'b0;
  endtask : drive
  task automatic settle;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 40) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (exp_q.size() != 0) begin
      err_total++;
      $display("[FAIL] %0t status change missing", $time);
      conclude();
    end
  endtask : settle
  task automatic step(input logic [3:0] c, input logic [4:0] e, input logic k,
    input logic [7:0] s);
    note(s);
    drive(c, e, k);
    settle();
  endtask : step
  task automatic open_sock(input scas_pkg::scas_mode_t m, input logic [7:0] s);
    @(posedge sys_clk_in);
    mode <= m;
    step(4'h8, 5'h00, 1'b0, s);
  endtask : open_sock
  // random delay, 7 to 15 counts with this seed, exercises slow answers from the peer
  task automatic resolve(input logic [3:0] c, input logic ans, input logic [7:0] back);
    rnd = lfsr(rnd);
    @(posedge sys_clk_in);
    answer <= ans;
    delay <= rnd[3:0];
    peer_addr <= {rnd, ~rnd, rnd ^ 16'ha5c3};
    dest_ip <= {rnd, ~rnd};
    note(8'h01);
    exp_flag = exp_flag | !ans;
    note(back);
    drive(c, 5'h00, 1'b0);
    @(negedge sys_clk_in);
    check(48'(req), 48'h1);
    settle();
    if (ans) check(hw_addr, peer_addr);
    check(48'(req), 48'h0);
  endtask : resolve
  task automatic clear_flag;
    exp_flag = 1'b0;
    step(4'h0, 5'h00, 1'b1, exp_code);
  endtask : clear_flag
  always @(negedge sys_clk_in) begin
    if (!resetn_in) prev = 9'h000;
    else if ({flag, code} !== prev) begin
      if (exp_q.size() == 0) check(48'({flag, code}), 48'(prev));
      else check(48'({flag, code}), 48'(exp_q.pop_front()));
      prev = {flag, code};
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(negedge sys_clk_in);
    check(48'(code), 48'(scas_pkg::SCAS_CODE_CLOSED));
    open_sock(scas_pkg::SCAS_MODE_UDP, 8'h22);
    resolve(4'h2, 1'b1, 8'h22);
    drive(4'h2, 5'h00, 1'b0);
    repeat (4) @(negedge sys_clk_in);
    check(48'(req), 48'h0);
    check(hw_addr, peer_addr);
    resolve(4'h2, 1'b0, 8'h22);
    clear_flag();
    step(4'h1, 5'h00, 1'b0, 8'h00);
    open_sock(scas_pkg::SCAS_MODE_RAW, 8'h32);
    resolve(4'h2, 1'b1, 8'h32);
    resolve(4'h2, 1'b0, 8'h32);
    clear_flag();
    step(4'h1, 5'h00, 1'b0, 8'h00);
    open_sock(scas_pkg::SCAS_MODE_TCP, 8'h13);
    resolve(4'h4, 1'b1, 8'h15);
    step(4'h0, 5'h10, 1'b0, 8'h1d);
    exp_flag = 1'b1;
    step(4'h0, 5'h04, 1'b0, 8'h00);
    clear_flag();
    open_sock(scas_pkg::SCAS_MODE_TCP, 8'h13);
    resolve(4'h4, 1'b0, 8'h00);
    clear_flag();
    // a peer ack closes quietly: the flag must stay clear
    open_sock(scas_pkg::SCAS_MODE_TCP, 8'h13);
    resolve(4'h4, 1'b1, 8'h15);
    step(4'h0, 5'h10, 1'b0, 8'h1d);
    step(4'h0, 5'h08, 1'b0, 8'h00);
    conclude();
  end
endmodule : scas_socket_fsm_test
